// [design/pin_sync.sv]
// two flip-flop synchroniser for a group of pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_in,  // core clock
    input  wire logic         reset_in,    // async reset, active high
    input  wire logic [W-1:0] async_in,    // raw pins
    output logic      [W-1:0] sync_out     // synchronised pins
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ======================================================================
    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

`default_nettype wire

// [design/signature_measurement_core.sv]
// signature analyser measurement core: polarity, window, sampler, shift register
//
// Strobed register access and the placing of the registers were left to the implementer.
`include "signature_params.svh"
`timescale 1ns/1ps
`default_nettype none

module signature_measurement_core (
    input  wire logic                   ref_clk_in,             // core clock, 250 MHz
    input  wire logic                   reset_in,               // async reset, active high
    input  wire logic                   probe_data_in,          // data line from probe
    input  wire logic                   first_timing_input_in,  // start pin of pod
    input  wire logic                   second_timing_input_in, // stop or qualifier pin
    input  wire logic                   dut_clock_in,           // clock of circuit under test
    input  wire logic [`SIG_ADDR_W-1:0] addr_in,                // register byte address
    input  wire logic [`SIG_DATA_W-1:0] wdata_in,               // write data
    input  wire logic                   wr_in,                  // write strobe
    input  wire logic                   rd_in,                  // read strobe
    output logic      [`SIG_DATA_W-1:0] rdata_out,              // read data, cycle after rd
    output logic                        serial_signature_out,   // residue bit now presented
    output logic                        window_open_out,        // measurement window open
    output logic                        result_ready_out,       // residue frozen and ready
    output logic                        probe_high_seen_out,    // high level seen on probe
    output logic                        probe_low_seen_out,     // low level seen on probe
    output logic                        irq_out                 // level interrupt
);

    // ======================================================================
    // pin synchronisers
    signature_pkg::pins_t pins_raw;
    signature_pkg::pins_t pins_s;

    assign pins_raw = '{probe_data:    probe_data_in,
                        first_timing:  first_timing_input_in,
                        second_timing: second_timing_input_in,
                        dut_clock:     dut_clock_in};

    pin_sync #(
        .W ($bits(signature_pkg::pins_t))
    ) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .async_in   (pins_raw),
        .sync_out   (pins_s)
    );

    // ======================================================================
    // state
    signature_pkg::ctrl_t       ctrl_ff,  nxt_ctrl;
    signature_pkg::gate_state_t gate_ff,  nxt_gate;
    logic [`FSR_W-1:0]          feedback_shift_register_ff, nxt_feedback_shift_register;
    logic [`STROBE_CNT_W-1:0]   strobe_cnt_ff, nxt_strobe_cnt;
    logic [`IRQ_W-1:0]          irq_stat_ff, nxt_irq_stat;
    logic [`IRQ_W-1:0]          irq_mask_ff, nxt_irq_mask;
    logic [`SIG_DATA_W-1:0]     rdata_ff, nxt_rdata;
    logic                       clk_prev_ff, nxt_clk_prev;
    logic                       begin_prev_ff, nxt_begin_prev;
    logic                       end_prev_ff, nxt_end_prev;
    logic                       qual_ff, nxt_qual;
    logic                       sample_ff, nxt_sample;
    logic                       high_seen_ff, nxt_high_seen;
    logic                       low_seen_ff, nxt_low_seen;
    logic                       ser_ff, nxt_ser;
    logic                       win_ff, nxt_win;
    logic                       ready_ff, nxt_ready;
    logic                       irq_ff, nxt_irq;

    // ======================================================================
    // polarity and mode selection
    logic clk_sel;
    logic begin_sel;
    logic end_sel;
    logic qual_sel;
    logic clk_edge;
    logic begin_edge;
    logic end_edge;
    logic feedback_bit;
    logic wr_ctrl;
    logic wr_strobe;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic arm_req;
    logic clr_levels;
    logic [`IRQ_W-1:0] events;

    always_comb begin
        clk_sel   = pins_s.dut_clock ^ ctrl_ff.clk_pol;
        begin_sel = pins_s.first_timing ^ ctrl_ff.begin_pol;
        // qualified mode takes both start and stop from the first input
        end_sel   = (ctrl_ff.qual_mode ? pins_s.first_timing
                                       : pins_s.second_timing) ^ ctrl_ff.end_pol;
        qual_sel  = pins_s.second_timing ^ ctrl_ff.qual_pol;
        clk_edge   = clk_sel & ~clk_prev_ff;
        begin_edge = clk_edge & begin_sel & ~begin_prev_ff;
        end_edge   = clk_edge & end_sel & ~end_prev_ff;
        feedback_bit = pins_s.probe_data
                     ^ feedback_shift_register_ff[`FSR_TAP_A]
                     ^ feedback_shift_register_ff[`FSR_TAP_B]
                     ^ feedback_shift_register_ff[`FSR_TAP_C]
                     ^ feedback_shift_register_ff[`FSR_TAP_D];
    end

    // ======================================================================
    // register bus decode
    always_comb begin
        wr_ctrl     = 1'b0;
        wr_strobe   = 1'b0;
        wr_irq_stat = 1'b0;
        wr_irq_mask = 1'b0;
        if (wr_in && addr_in == `OFF_CONTROL) begin
            wr_ctrl = 1'b1;
        end else if (wr_in && addr_in == `OFF_STROBE) begin
            wr_strobe = 1'b1;
        end else if (wr_in && addr_in == `OFF_IRQ_STATUS) begin
            wr_irq_stat = 1'b1;
        end else if (wr_in && addr_in == `OFF_IRQ_MASK) begin
            wr_irq_mask = 1'b1;
        end
        arm_req    = wr_ctrl & wdata_in[`CTRL_ARM_BIT];
        clr_levels = wr_ctrl & wdata_in[`CTRL_CLR_BIT];
    end

    // ======================================================================
    // next-state logic
    always_comb begin
        nxt_ctrl       = ctrl_ff;
        nxt_gate       = gate_ff;
        nxt_feedback_shift_register = feedback_shift_register_ff;
        nxt_strobe_cnt = strobe_cnt_ff;
        nxt_irq_mask   = irq_mask_ff;
        nxt_clk_prev   = clk_sel;
        nxt_begin_prev = begin_prev_ff;
        nxt_end_prev   = end_prev_ff;
        nxt_sample     = sample_ff;
        events         = '0;

        if (wr_ctrl) begin
            nxt_ctrl = signature_pkg::ctrl_t'(wdata_in[`CTRL_SET_W-1:0]);
        end
        if (wr_irq_mask) begin
            nxt_irq_mask = wdata_in[`IRQ_W-1:0];
        end

        if (clk_edge) begin
            nxt_begin_prev = begin_sel;
            nxt_end_prev   = end_sel;
            nxt_sample     = pins_s.probe_data;
        end

        // the flip-flop is held preset outside qualified mode
        if (!ctrl_ff.qual_mode) begin
            nxt_qual = 1'b1;
        end else if (clk_edge) begin
            nxt_qual = qual_sel;
        end else begin
            nxt_qual = qual_ff;
        end

        // window machine runs on the selected clock edge once armed
        case (gate_ff)
            signature_pkg::GATE_IDLE: begin
                nxt_gate = gate_ff;
            end
            signature_pkg::GATE_ARMED: begin
                // a stop before the start is simply ignored here
                if (begin_edge) begin
                    nxt_gate = signature_pkg::GATE_OPEN;
                    events[`IRQ_OPEN_BIT] = 1'b1;
                end
            end
            signature_pkg::GATE_OPEN: begin
                if (end_edge) begin
                    nxt_gate = signature_pkg::GATE_DONE;
                    events[`IRQ_DONE_BIT] = 1'b1;
                end else if (clk_edge && ctrl_ff.shift_en && qual_ff) begin
                    nxt_feedback_shift_register =
                        {feedback_shift_register_ff[`FSR_W-2:0], feedback_bit};
                end
            end
            signature_pkg::GATE_DONE: begin
                // clock gated off; only readout strobes move the residue
                if (wr_strobe) begin
                    nxt_feedback_shift_register =
                        {feedback_shift_register_ff[`FSR_W-2:0],
                         feedback_shift_register_ff[`FSR_W-1]};
                    nxt_strobe_cnt = strobe_cnt_ff + `STROBE_CNT_W'(1);
                end
            end
            default: begin
                nxt_gate = signature_pkg::GATE_IDLE;
            end
        endcase

        // arming wins over any window activity in the same cycle, except the open and done interrupt events
        if (arm_req) begin
            nxt_gate       = signature_pkg::GATE_ARMED;
            nxt_feedback_shift_register = `FSR_RESET;
            nxt_strobe_cnt = '0;
        end

        // sticky latches: a new level beats the clear
        nxt_high_seen = (high_seen_ff & ~clr_levels) | pins_s.probe_data;
        nxt_low_seen  = (low_seen_ff & ~clr_levels) | ~pins_s.probe_data;

        // set wins over write-one-to-clear
        nxt_irq_stat = (irq_stat_ff & ~(wr_irq_stat ? wdata_in[`IRQ_W-1:0] : '0)) | events;
        nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);

        // rotation keeps the residue intact after the full sixteen strobes
        nxt_ser   = nxt_feedback_shift_register[`FSR_W-1];
        nxt_win   = (nxt_gate == signature_pkg::GATE_OPEN);
        nxt_ready = (nxt_gate == signature_pkg::GATE_DONE);
    end

    // ======================================================================
    // read data, valid the cycle after the read strobe only
    always_comb begin
        nxt_rdata = '0;
        if (rd_in && addr_in == `OFF_CONTROL) begin
            nxt_rdata = {{(`SIG_DATA_W-`CTRL_SET_W){1'b0}}, ctrl_ff};
        end else if (rd_in && addr_in == `OFF_STATUS) begin
            nxt_rdata = {{(`SIG_DATA_W-10){1'b0}}, strobe_cnt_ff,
                         sample_ff, low_seen_ff, high_seen_ff, ready_ff, win_ff};
        end else if (rd_in && addr_in == `OFF_RESIDUE) begin
            nxt_rdata = {{(`SIG_DATA_W-`FSR_W){1'b0}}, feedback_shift_register_ff};
        end else if (rd_in && addr_in == `OFF_STROBE) begin
            nxt_rdata = {{(`SIG_DATA_W-1){1'b0}}, ser_ff};
        end else if (rd_in && addr_in == `OFF_IRQ_STATUS) begin
            nxt_rdata = {{(`SIG_DATA_W-`IRQ_W){1'b0}}, irq_stat_ff};
        end else if (rd_in && addr_in == `OFF_IRQ_MASK) begin
            nxt_rdata = {{(`SIG_DATA_W-`IRQ_W){1'b0}}, irq_mask_ff};
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_ff        <= '0;
            gate_ff        <= signature_pkg::GATE_IDLE;
            feedback_shift_register_ff <= `FSR_RESET;
            strobe_cnt_ff  <= '0;
            irq_stat_ff    <= '0;
            irq_mask_ff    <= '0;
            rdata_ff       <= '0;
            clk_prev_ff    <= 1'b0;
            begin_prev_ff  <= 1'b0;
            end_prev_ff    <= 1'b0;
            qual_ff        <= 1'b1;
            sample_ff      <= 1'b0;
            high_seen_ff   <= 1'b0;
            low_seen_ff    <= 1'b0;
            ser_ff         <= 1'b0;
            win_ff         <= 1'b0;
            ready_ff       <= 1'b0;
            irq_ff         <= 1'b0;
        end else begin
            ctrl_ff        <= nxt_ctrl;
            gate_ff        <= nxt_gate;
            feedback_shift_register_ff <= nxt_feedback_shift_register;
            strobe_cnt_ff  <= nxt_strobe_cnt;
            irq_stat_ff    <= nxt_irq_stat;
            irq_mask_ff    <= nxt_irq_mask;
            rdata_ff       <= nxt_rdata;
            clk_prev_ff    <= nxt_clk_prev;
            begin_prev_ff  <= nxt_begin_prev;
            end_prev_ff    <= nxt_end_prev;
            qual_ff        <= nxt_qual;
            sample_ff      <= nxt_sample;
            high_seen_ff   <= nxt_high_seen;
            low_seen_ff    <= nxt_low_seen;
            ser_ff         <= nxt_ser;
            win_ff         <= nxt_win;
            ready_ff       <= nxt_ready;
            irq_ff         <= nxt_irq;
        end
    end

    assign rdata_out            = rdata_ff;
    assign serial_signature_out = ser_ff;
    assign window_open_out      = win_ff;
    assign result_ready_out     = ready_ff;
    assign probe_high_seen_out  = high_seen_ff;
    assign probe_low_seen_out   = low_seen_ff;
    assign irq_out              = irq_ff;

endmodule

`default_nettype wire

// [shared/signature_params.svh]
// offsets, field positions and reset values of the signature measurement core
`ifndef SIGNATURE_PARAMS_SVH
`define SIGNATURE_PARAMS_SVH

// ==========================================================================
// register bus
`define SIG_ADDR_W       8
`define SIG_DATA_W       32
`define OFF_CONTROL      8'h00
`define OFF_STATUS       8'h04
`define OFF_RESIDUE      8'h08
`define OFF_STROBE       8'h0C
`define OFF_IRQ_STATUS   8'h10
`define OFF_IRQ_MASK     8'h14

// ==========================================================================
// control register: bits 5..0 hold settings, 6 and 7 are write-only pulses
`define CTRL_SET_W       6
`define CTRL_ARM_BIT     6
`define CTRL_CLR_BIT     7

// ==========================================================================
// interrupt status and mask layout
`define IRQ_W            2
`define IRQ_DONE_BIT     0
`define IRQ_OPEN_BIT     1

// ==========================================================================
// feedback shift register
`define FSR_W            16
`define FSR_TAP_A        15
`define FSR_TAP_B        11
`define FSR_TAP_C        8
`define FSR_TAP_D        6
`define FSR_RESET        16'h0000
`define STROBE_CNT_W     5

`endif

// [shared/signature_pkg.sv]
// types shared by the signature measurement core
package signature_pkg;

    // ======================================================================
    // settings written by software
    typedef struct packed {
        logic shift_en;
        logic qual_pol;
        logic clk_pol;
        logic end_pol;
        logic begin_pol;
        logic qual_mode;
    } ctrl_t;

    // ======================================================================
    // synchronised pins from the probe and pod
    typedef struct packed {
        logic probe_data;
        logic first_timing;
        logic second_timing;
        logic dut_clock;
    } pins_t;

    // ======================================================================
    // window state machine
    typedef enum logic [3:0] {
        GATE_IDLE  = 4'b0001,
        GATE_ARMED = 4'b0010,
        GATE_OPEN  = 4'b0100,
        GATE_DONE  = 4'b1000
    } gate_state_t;

endpackage

// [sim/dut_pod_model.sv]
// model of the circuit under test driving the probe and timing pod pins
`timescale 1ns/1ps
`default_nettype none

module dut_pod_model (
    input  wire logic clk_inv_in, // clock polarity chosen by software
    output logic      dclk_out,   // clock of the circuit under test
    output logic      first_out,  // first timing pin
    output logic      second_out, // second timing pin
    output logic      data_out    // probe data line
);
    logic hi;
    int   lo_ns;

    // selected clock stays low between frames, whatever polarity is chosen
    assign dclk_out = hi ^ clk_inv_in;

    initial begin
        hi         = 1'b0;
        first_out  = 1'b0;
        second_out = 1'b0;
        data_out   = 1'b0;
        lo_ns      = 40;
    end

    task automatic pins(input logic d, input logic f, input logic s);
        data_out   = d;
        first_out  = f;
        second_out = s;
    endtask

    // pins move mid low phase, so they are settled long before the edge
    task automatic tick(input logic d, input logic f, input logic s);
        #(lo_ns / 2);
        pins(d, f, s);
        #(lo_ns / 2);
        hi = 1'b1;
        #40;
        hi = 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/signature_measurement_core_sva.sv]
// concurrent checks on the ports of the signature measurement core
`include "signature_params.svh"
`timescale 1ns/1ps
`default_nettype none

module signature_measurement_core_sva (
    input wire logic                   ref_clk_in,           // core clock
    input wire logic                   reset_in,             // async reset
    input wire logic [`SIG_ADDR_W-1:0] addr_in,              // address
    input wire logic [`SIG_DATA_W-1:0] wdata_in,             // write data
    input wire logic                   wr_in,                // write strobe
    input wire logic                   rd_in,                // read strobe
    input wire logic [`SIG_DATA_W-1:0] rdata_out,            // read data
    input wire logic                   serial_signature_out, // residue bit
    input wire logic                   window_open_out,      // window
    input wire logic                   result_ready_out,     // ready
    input wire logic                   probe_high_seen_out,  // high seen
    input wire logic                   probe_low_seen_out,   // low seen
    input wire logic                   irq_out               // interrupt
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    logic ctl_wr;
    logic arm_wr;
    logic clr_wr;
    assign ctl_wr = wr_in && addr_in == `OFF_CONTROL;
    assign arm_wr = ctl_wr && wdata_in[`CTRL_ARM_BIT];
    assign clr_wr = ctl_wr && wdata_in[`CTRL_CLR_BIT];

    // ======================================================================
    // assertions
    property p_rdata_idle; !$past(rd_in) |-> rdata_out == '0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_ready_excl; result_ready_out |-> !window_open_out; endproperty
    a_ready_excl: assert property (p_ready_excl) else $error("ready while window open");
    property p_close_done;
        $fell(window_open_out) && !$past(ctl_wr) && !$past(ctl_wr, 2) |-> ##[0:1] result_ready_out;
    endproperty
    a_close_done: assert property (p_close_done) else $error("window closed, no result");
    property p_frozen; (result_ready_out && !wr_in)[*3] |=> $stable(serial_signature_out); endproperty
    a_frozen: assert property (p_frozen) else $error("residue moved while frozen");
    property p_open_clean; $rose(window_open_out) |-> !$past(result_ready_out); endproperty
    a_open_clean: assert property (p_open_clean) else $error("window opened before arm");
    property p_ready_hold; $fell(result_ready_out) |-> $past(arm_wr) || $past(arm_wr, 2); endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped without arm");
    property p_high_hold; $fell(probe_high_seen_out) |-> $past(clr_wr) || $past(clr_wr, 2); endproperty
    a_high_hold: assert property (p_high_hold) else $error("high latch lost");
    property p_low_hold; $fell(probe_low_seen_out) |-> $past(clr_wr) || $past(clr_wr, 2); endproperty
    a_low_hold: assert property (p_low_hold) else $error("low latch lost");

    c_done: cover property ($rose(result_ready_out));
    c_open: cover property ($rose(window_open_out));
    c_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking testbench for the signature measurement core
`include "signature_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        ref_clk_in, reset_in, wr_in, rd_in, rd_q, clk_inv;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, seed;
    logic        serial_signature_out, window_open_out, result_ready_out;
    logic        probe_high_seen_out, probe_low_seen_out, irq_out;
    logic        dclk, first_pin, second_pin, data_pin;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0]  adr_q[$];
    int          err_total, comparisons;
    logic [5:0]  cfg_table[5] = '{6'h20, 6'h2E, 6'h0E, 6'h31, 6'h3F};

    signature_measurement_core u_signature_measurement_core (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .probe_data_in(data_pin),
        .first_timing_input_in(first_pin), .second_timing_input_in(second_pin),
        .dut_clock_in(dclk), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .serial_signature_out(serial_signature_out),
        .window_open_out(window_open_out), .result_ready_out(result_ready_out),
        .probe_high_seen_out(probe_high_seen_out), .probe_low_seen_out(probe_low_seen_out),
        .irq_out(irq_out));
    dut_pod_model u_pod (.clk_inv_in(clk_inv), .dclk_out(dclk), .first_out(first_pin),
        .second_out(second_pin), .data_out(data_pin));

    // ======================================================================
    // helpers
    function automatic logic rbit();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7];
    endfunction
    function automatic logic [15:0] step(input logic [15:0] r, input logic d);
        return {r[14:0], d ^ r[15] ^ r[11] ^ r[8] ^ r[6]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    // the expected word is noted here and compared when the data appear
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        adr_q.push_back(a);
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
    endtask

    always @(posedge ref_clk_in) rd_q <= rd_in;
    always @(negedge ref_clk_in) begin
        if (rd_q === 1'b1 && exp_q.size() > 0) begin
            chk($sformatf("rdata at %h", adr_q.pop_front()), rdata_out & msk_q.pop_front(),
                exp_q.pop_front());
        end
    end

    // ======================================================================
    // one measurement: configure, arm, frame of n clocks, read back
    task automatic measure(input logic [5:0] c, input int n, input logic [1:0] msk);
        logic [15:0] r, bits;
        logic        q, qp, d, qm;
        r  = 16'h0000;
        qp = 1'b1;
        qm = c[0];
        wr(`OFF_CONTROL, {26'h0, c});
        rd(`OFF_CONTROL, {26'h0, c}, 32'hFFFF_FFFF);
        wr(`OFF_IRQ_MASK, {30'h0, msk});
        rd(`OFF_IRQ_MASK, {30'h0, msk}, 32'hFFFF_FFFF);
        clk_inv <= c[3];
        // one edge at idle levels wipes start history left by a polarity change
        u_pod.tick(rbit(), c[1], qm ? c[4] : c[2]);
        cycles(8);
        wr(`OFF_CONTROL, {24'h0, 2'b01, c});
        rd(`OFF_RESIDUE, 32'h0, 32'hFFFF_FFFF);
        u_pod.tick(rbit(), ~c[1], qm ? ~c[4] : c[2]);
        @(negedge ref_clk_in);
        chk("window", {window_open_out, result_ready_out}, 2'b10);
        for (int i = 0; i < n; i++) begin
            d = rbit();
            q = qm ? rbit() : 1'b1;
            u_pod.tick(d, c[1], qm ? q ^ c[4] : c[2]);
            if (c[5] && qp) r = step(r, d);
            qp = q;
        end
        u_pod.tick(rbit(), c[1] ^ qm, qm ? c[4] : ~c[2]);
        repeat (3) u_pod.tick(rbit(), c[1], qm ? c[4] : c[2]);
        @(negedge ref_clk_in);
        chk("window", {window_open_out, result_ready_out}, 2'b01);
        chk("irq", irq_out, |msk);
        rd(`OFF_RESIDUE, {16'h0, r}, 32'hFFFF_FFFF);
        bits = 16'h0;
        for (int k = 0; k < 16; k++) begin
            cycles(3);
            @(negedge ref_clk_in);
            bits = {bits[14:0], serial_signature_out};
            rd(`OFF_STROBE, {31'h0, r[15 - k]}, 32'h1);
            wr(`OFF_STROBE, 32'h0);
        end
        for (int j = 0; j < 4; j++) chk("char", bits[15 - 4 * j -: 4], r[15 - 4 * j -: 4]);
        rd(`OFF_RESIDUE, {16'h0, r}, 32'hFFFF_FFFF);
        rd(`OFF_STATUS, 32'h0000_0202, 32'h0000_03E3);
        rd(`OFF_IRQ_STATUS, 32'h3, 32'hFFFF_FFFF);
        wr(`OFF_IRQ_STATUS, 32'h1);
        rd(`OFF_IRQ_STATUS, 32'h2, 32'hFFFF_FFFF);
        wr(`OFF_IRQ_STATUS, 32'h2);
        cycles(3);
        @(negedge ref_clk_in);
        chk("irq", irq_out, 1'b0);
    endtask

    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ======================================================================
    // clock, watchdog and main sequence
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #100000;
        err_total++;
        results();
    end
    initial begin
        reset_in    = 1'b1;
        {wr_in, rd_in, rd_q, clk_inv} = 4'h0;
        addr_in     = 8'h00;
        wdata_in    = 32'h0;
        seed        = 32'hF950AA7F;
        err_total   = 0;
        comparisons = 0;
        cycles(20);
        reset_in <= 1'b0;
        cycles(6);
        @(negedge ref_clk_in);
        chk("after reset", {irq_out, result_ready_out, window_open_out,
            probe_high_seen_out, probe_low_seen_out}, 5'b00001);
        rd(`OFF_CONTROL, 32'h0, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0, 32'hFFFF_FFFF);
        u_pod.pins(1'b1, 1'b0, 1'b0);
        cycles(6);
        @(negedge ref_clk_in);
        chk("levels", {probe_high_seen_out, probe_low_seen_out}, 2'b11);
        wr(`OFF_CONTROL, 32'h80);
        cycles(4);
        @(negedge ref_clk_in);
        chk("levels", {probe_high_seen_out, probe_low_seen_out}, 2'b10);
        u_pod.pins(1'b0, 1'b0, 1'b0);
        cycles(4);
        wr(`OFF_CONTROL, 32'h80);
        cycles(4);
        @(negedge ref_clk_in);
        chk("levels", {probe_high_seen_out, probe_low_seen_out}, 2'b01);
        // a slow partner in one frame: long low phase of its clock
        for (int i = 0; i < 5; i++) begin
            u_pod.lo_ns = (i == 2) ? 200 : 40;
            measure(cfg_table[i], 12 + 4 * i, (i == 0) ? 2'b00 : 2'b11);
        end
        cycles(10);
        results();
    end
endmodule

bind signature_measurement_core signature_measurement_core_sva u_sva (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .serial_signature_out(serial_signature_out), .window_open_out(window_open_out),
    .result_ready_out(result_ready_out), .probe_high_seen_out(probe_high_seen_out),
    .probe_low_seen_out(probe_low_seen_out), .irq_out(irq_out));
`default_nettype wire
